//--- rtl/csp_arith_flags.sv
// Purpose: derive carry, half-carry and overflow from an add or subtract
// Assumes: operands are presented by the execution unit in the same cycle
// Notes: purely combinational helper
`timescale 1ns/1ps
module csp_arith_flags #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] opA,
  input wire logic [WIDTH-1:0] opB,
  input wire logic carryIn,
  input wire logic subtract,
  output logic carryOut,
  output logic halfOut,
  output logic ovfOut
);
  import csp_pkg::*;
  initial begin
    if (WIDTH != 8) $error("csp_arith_flags serves 8-bit operands only");
  end
  logic [WIDTH:0] full;
  logic [4:0] low;
  logic [WIDTH-1:0] lower7;
  logic c7In;
  // ==========================================================
  // carry chain pieces; subtract uses a-b-c with borrow flags
  always_comb begin
    if (subtract) begin
      full = {1'b0, opA} - {1'b0, opB} - {{WIDTH{1'b0}}, carryIn};
      low = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn};
      lower7 = {1'b0, opA[6:0]} - {1'b0, opB[6:0]} - {7'h00, carryIn};
    end else begin
      full = {1'b0, opA} + {1'b0, opB} + {{WIDTH{1'b0}}, carryIn};
      low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
      lower7 = {1'b0, opA[6:0]} + {1'b0, opB[6:0]} + {7'h00, carryIn};
    end
    c7In = lower7[7];
  end
  assign carryOut = full[WIDTH];
  assign halfOut = low[4];
  assign ovfOut = c7In ^ full[WIDTH];
endmodule : csp_arith_flags

//--- rtl/csp_core_status.sv
// Purpose: status word, pointer select, pointer control and data pointers
// Assumes: register port and execution strobes synchronous to core_clk
// Notes: one write and one read per cycle on the register port
`timescale 1ns/1ps
`include "csp_defines.svh"
module csp_core_status #(
  parameter int PTR_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrRe,
  input wire logic [7:0] mainWorkReg,
  input wire logic [7:0] aluOpA,
  input wire logic [7:0] aluOpB,
  input wire logic aluSub,
  input wire logic aluUseCarry,
  input wire logic aluValid,
  input wire csp_pkg::csp_flag_upd_t flagUpd,
  input wire logic externalMoveDone,
  output logic [7:0] sfrRdata,
  output logic [7:0] statusWord,
  output logic activePointerBit,
  output logic [PTR_WIDTH-1:0] moveAddr,
  output logic [7:0] bankBase
);
  import csp_pkg::*;

  // ==========================================================
  // elaboration check
  // the byte lanes of the pointer registers assume two bytes each
  if (PTR_WIDTH != 16) begin : g_bad_ptr_width
    $error("csp_core_status needs 16-bit pointers");
  end

  // ==========================================================
  // local constants
  // two pointers, each with its own step control copy
  localparam int NUM_PTR = 2;
  localparam logic [PTR_WIDTH-1:0] STEP_ONE = `CSP_STEP_SMALL;
  localparam logic [PTR_WIDTH-1:0] STEP_TWO = `CSP_STEP_LARGE;

  // ==========================================================
  // state
  // status word, bit 0 is the registered parity copy
  logic [7:0] statusWord_reg;
  logic [7:0] statusWord_next;
  // which pointer is active
  logic activePointerBit_reg;
  logic activePointerBit_next;
  // per-pointer step control copies
  csp_step_ctl_t stepCtl_reg [NUM_PTR];
  csp_step_ctl_t stepCtl_next [NUM_PTR];
  // per-pointer address values
  logic [PTR_WIDTH-1:0] dataPtr_reg [NUM_PTR];
  logic [PTR_WIDTH-1:0] dataPtr_next [NUM_PTR];
  // registered copies behind the outputs
  logic [7:0] sfrRdata_reg;
  logic [7:0] sfrRdata_next;
  logic [PTR_WIDTH-1:0] moveAddr_reg;
  logic [PTR_WIDTH-1:0] moveAddr_next;
  logic [7:0] bankBase_reg;
  logic [7:0] bankBase_next;

  // ==========================================================
  // combinational helpers
  // flags computed from the operands of the current operation
  logic aluCarry;
  logic aluHalf;
  logic aluOvf;
  // parity of the work register as it stands now
  logic parityNow;
  // control copy, pointer and step of the active pointer
  csp_step_ctl_t curCtl;
  logic [PTR_WIDTH-1:0] curPtr;
  logic [PTR_WIDTH-1:0] stepAmt;
  logic [PTR_WIDTH-1:0] steppedPtr;
  // register port write decode
  logic wrStatus;
  logic wrSelect;
  logic wrStepCtl;
  logic [NUM_PTR-1:0] wrPtrLow;
  logic [NUM_PTR-1:0] wrPtrHigh;
  // bank field of the next status word
  csp_bank_t bankNext;

  // ==========================================================
  // register port write decode
  assign wrStatus = sfrWe && (sfrAddr == `CSP_ADDR_STATUS);
  assign wrSelect = sfrWe && (sfrAddr == `CSP_ADDR_PTR_SEL);
  assign wrStepCtl = sfrWe && (sfrAddr == `CSP_ADDR_STEP_CTL);
  // low byte and high byte of each pointer
  assign wrPtrLow[0] = sfrWe && (sfrAddr == `CSP_ADDR_PTR0_LO);
  assign wrPtrHigh[0] = sfrWe && (sfrAddr == `CSP_ADDR_PTR0_HI);
  assign wrPtrLow[1] = sfrWe && (sfrAddr == `CSP_ADDR_PTR1_LO);
  assign wrPtrHigh[1] = sfrWe && (sfrAddr == `CSP_ADDR_PTR1_HI);

  // ==========================================================
  // arithmetic flag helper
  // carry feeds back in only when the operation asks for it
  csp_arith_flags #(.WIDTH(8)) uFlags (
    .opA(aluOpA),
    .opB(aluOpB),
    .carryIn(aluUseCarry & statusWord_reg[`CSP_STAT_CARRY]),
    .subtract(aluSub),
    .carryOut(aluCarry),
    .halfOut(aluHalf),
    .ovfOut(aluOvf)
  );

  // ==========================================================
  // live parity, active control copy and step arithmetic
  assign parityNow = ^mainWorkReg;
  // the selected copy is the one seen by software and used for steps
  assign curCtl = stepCtl_reg[activePointerBit_reg];
  assign curPtr = dataPtr_reg[activePointerBit_reg];
  // size bit clear steps by one, set steps by two
  assign stepAmt = curCtl.sizeTwo ? STEP_TWO : STEP_ONE;
  // direction bit clear counts up, set counts down; wraps at the ends
  assign steppedPtr = curCtl.dirDown ? (curPtr - stepAmt) :
    (curPtr + stepAmt);

  // ==========================================================
  // status word
  // hardware flag updates win over a same-cycle software write
  always_comb begin
    statusWord_next = statusWord_reg;
    // software writes every bit but parity
    if (wrStatus) begin
      statusWord_next[7:1] = sfrWdata[7:1];
    end
    // an arithmetic result loads the three result flags
    if (aluValid) begin
      statusWord_next[`CSP_STAT_CARRY] = aluCarry;
      statusWord_next[`CSP_STAT_HALF] = aluHalf;
      statusWord_next[`CSP_STAT_SIGNED] = aluOvf;
    end
    // direct flag writes from boolean instructions come last
    if (flagUpd.carryWe) begin
      statusWord_next[`CSP_STAT_CARRY] = flagUpd.carryVal;
    end
    if (flagUpd.halfWe) begin
      statusWord_next[`CSP_STAT_HALF] = flagUpd.halfVal;
    end
    if (flagUpd.ovfWe) begin
      statusWord_next[`CSP_STAT_SIGNED] = flagUpd.ovfVal;
    end
    // parity never comes from the port, only from the work register
    statusWord_next[`CSP_STAT_PARITY] = parityNow;
  end

  // status word register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusWord_reg <= `CSP_STAT_RESET;
    end else begin
      statusWord_reg <= statusWord_next;
    end
  end

  // ==========================================================
  // pointer select
  // a finished move beats a same-cycle software write of the select
  always_comb begin
    activePointerBit_next = activePointerBit_reg;
    if (wrSelect) begin
      activePointerBit_next = sfrWdata[0];
    end
    // an equal next-select value reloads the same pointer: no switch
    if (externalMoveDone) begin
      activePointerBit_next = curCtl.nextSel;
    end
  end

  // pointer select register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      activePointerBit_reg <= `CSP_SEL_RESET;
    end else begin
      activePointerBit_reg <= activePointerBit_next;
    end
  end

  // ==========================================================
  // per-pointer control copy and pointer value
  for (genvar p = 0; p < NUM_PTR; p++) begin : g_ptr
    logic isActive;
    assign isActive = (activePointerBit_reg == 1'(p));

    // only the selected copy takes a port write
    always_comb begin
      stepCtl_next[p] = stepCtl_reg[p];
      if (wrStepCtl && isActive) begin
        stepCtl_next[p] = csp_step_ctl_t'(sfrWdata[3:0]);
      end
    end

    // byte writes, then the step after a move through this pointer
    always_comb begin
      dataPtr_next[p] = dataPtr_reg[p];
      if (wrPtrLow[p]) begin
        dataPtr_next[p][7:0] = sfrWdata;
      end
      if (wrPtrHigh[p]) begin
        dataPtr_next[p][15:8] = sfrWdata;
      end
      // the step uses the copy selected before the move switches
      if (externalMoveDone && isActive && curCtl.stepEn) begin
        dataPtr_next[p] = steppedPtr;
      end
    end

    // control copy and pointer registers
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        stepCtl_reg[p] <= `CSP_CTL_RESET;
        dataPtr_reg[p] <= `CSP_PTR_RESET;
      end else begin
        stepCtl_reg[p] <= stepCtl_next[p];
        dataPtr_reg[p] <= dataPtr_next[p];
      end
    end
  end

  // ==========================================================
  // read data
  // held until the next read strobe; unmapped addresses read zero
  always_comb begin
    sfrRdata_next = sfrRdata_reg;
    if (sfrRe) begin
      case (sfrAddr)
        `CSP_ADDR_STATUS: begin
          sfrRdata_next = {statusWord_reg[7:1], parityNow};
        end
        `CSP_ADDR_PTR_SEL: begin
          sfrRdata_next = {7'h00, activePointerBit_reg};
        end
        `CSP_ADDR_STEP_CTL: begin
          sfrRdata_next = {4'h0, curCtl};
        end
        `CSP_ADDR_PTR0_LO: begin
          sfrRdata_next = dataPtr_reg[0][7:0];
        end
        `CSP_ADDR_PTR0_HI: begin
          sfrRdata_next = dataPtr_reg[0][15:8];
        end
        `CSP_ADDR_PTR1_LO: begin
          sfrRdata_next = dataPtr_reg[1][7:0];
        end
        `CSP_ADDR_PTR1_HI: begin
          sfrRdata_next = dataPtr_reg[1][15:8];
        end
        default: begin
          sfrRdata_next = `CSP_RDATA_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // move address and bank base
  // both follow the next state so they change on the same edge
  always_comb begin
    moveAddr_next = dataPtr_next[activePointerBit_next];
  end

  assign bankNext = csp_bank_t'(
    statusWord_next[`CSP_STAT_BANK_HI:`CSP_STAT_BANK_LO]);

  // eight working registers per bank, banks stacked upward
  always_comb begin
    case (bankNext)
      CSP_BANK0: bankBase_next = `CSP_BANK0_BASE;
      CSP_BANK1: bankBase_next = `CSP_BANK1_BASE;
      CSP_BANK2: bankBase_next = `CSP_BANK2_BASE;
      CSP_BANK3: bankBase_next = `CSP_BANK3_BASE;
      default: bankBase_next = `CSP_BANK0_BASE;
    endcase
  end

  // output registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdata_reg <= `CSP_RDATA_RESET;
      moveAddr_reg <= `CSP_PTR_RESET;
      bankBase_reg <= `CSP_BANK0_BASE;
    end else begin
      sfrRdata_reg <= sfrRdata_next;
      moveAddr_reg <= moveAddr_next;
      bankBase_reg <= bankBase_next;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign sfrRdata = sfrRdata_reg;
  assign statusWord = statusWord_reg;
  assign activePointerBit = activePointerBit_reg;
  assign moveAddr = moveAddr_reg;
  assign bankBase = bankBase_reg;

endmodule : csp_core_status

//--- rtl/csp_defines.svh
// Purpose: constants for the core status and pointer control block
// Assumes: 8-bit special function register port, one clock
// Notes: offsets are register addresses on the internal register port
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH
`define CSP_ADDR_STATUS 8'hd0
`define CSP_ADDR_PTR_SEL 8'h92
`define CSP_ADDR_STEP_CTL 8'h93
`define CSP_ADDR_PTR0_LO 8'h82
`define CSP_ADDR_PTR0_HI 8'h83
`define CSP_ADDR_PTR1_LO 8'h84
`define CSP_ADDR_PTR1_HI 8'h85
`define CSP_STAT_CARRY 7
`define CSP_STAT_HALF 6
`define CSP_STAT_USER0 5
`define CSP_STAT_BANK_HI 4
`define CSP_STAT_BANK_LO 3
`define CSP_STAT_SIGNED 2
`define CSP_STAT_USER1 1
`define CSP_STAT_PARITY 0
`define CSP_CTL_NEXT 3
`define CSP_CTL_SIZE 2
`define CSP_CTL_DIR 1
`define CSP_CTL_EN 0
`define CSP_CTL_MASK 8'h0f
`define CSP_STAT_RESET 8'h00
`define CSP_CTL_RESET 4'h0
`define CSP_SEL_RESET 1'b0
`define CSP_PTR_RESET 16'h0000
`define CSP_RDATA_RESET 8'h00
`define CSP_STEP_SMALL 16'h0001
`define CSP_STEP_LARGE 16'h0002
`define CSP_BANK0_BASE 8'h00
`define CSP_BANK1_BASE 8'h08
`define CSP_BANK2_BASE 8'h10
`define CSP_BANK3_BASE 8'h18
`endif

//--- rtl/csp_pkg.sv
// Purpose: types for the core status and pointer control block
// Assumes: defines header included alongside
// Notes: flag update bundle comes from the execution unit
package csp_pkg;
  // ==========================================================
  // flag update request from the execution unit
  typedef struct packed {
    logic carryWe;
    logic carryVal;
    logic halfWe;
    logic halfVal;
    logic ovfWe;
    logic ovfVal;
  } csp_flag_upd_t;
  // per-pointer control copy
  typedef struct packed {
    logic nextSel;
    logic sizeTwo;
    logic dirDown;
    logic stepEn;
  } csp_step_ctl_t;
  typedef enum logic [1:0] {
    CSP_BANK0 = 2'b00,
    CSP_BANK1 = 2'b01,
    CSP_BANK2 = 2'b10,
    CSP_BANK3 = 2'b11
  } csp_bank_t;
endpackage : csp_pkg

//--- tb/csp_core_status_properties.sv
// Purpose: port checks for the status and pointer block
// Assumes: bound to csp_core_status, one clock domain
// Notes: read data is registered, parity lags one cycle
`timescale 1ns/1ps
module csp_core_status_properties #(
  parameter int PTR_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrRe,
  input wire logic [7:0] mainWorkReg,
  input wire logic aluValid,
  input wire csp_pkg::csp_flag_upd_t flagUpd,
  input wire logic externalMoveDone,
  input wire logic [7:0] sfrRdata,
  input wire logic [7:0] statusWord,
  input wire logic activePointerBit,
  input wire logic [PTR_WIDTH-1:0] moveAddr,
  input wire logic [7:0] bankBase
);
  import csp_pkg::*;
  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_parity_lag: assert property ($past(arst_n) |->
    statusWord[0] == ^$past(mainWorkReg)) else $error("parity lag");
  a_bank_map: assert property (
    bankBase == {3'h0, statusWord[4:3], 3'h0}) else $error("bank base");
  a_sel_hold: assert property (!externalMoveDone &&
    !(sfrWe && sfrAddr == 8'h92) |=> $stable(activePointerBit))
    else $error("select moved");
  a_ptr_hold: assert property (!externalMoveDone && !sfrWe
    |=> $stable(moveAddr)) else $error("pointer moved");
  a_status_read: assert property (sfrRe && !sfrWe &&
    sfrAddr == 8'hd0 |=> sfrRdata ==
    {$past(statusWord[7:1]), ^$past(mainWorkReg)})
    else $error("status read");
  a_ctl_upper_zero: assert property (sfrRe &&
    sfrAddr == 8'h93 |=> sfrRdata[7:4] == 4'h0) else $error("upper bits");
  a_sel_read: assert property (sfrRe && !sfrWe &&
    sfrAddr == 8'h92 |=> sfrRdata == {7'h0, $past(activePointerBit)})
    else $error("select read");
  a_status_write: assert property (sfrWe &&
    sfrAddr == 8'hd0 && !aluValid && flagUpd == '0
    |=> statusWord[7:1] == $past(sfrWdata[7:1]))
    else $error("status write");
  a_carry_direct: assert property (flagUpd.carryWe |=>
    statusWord[7] == $past(flagUpd.carryVal)) else $error("carry write");
  c_move: cover property (externalMoveDone ##1 activePointerBit);
  c_alu: cover property (aluValid);
  c_status_write: cover property (sfrWe && sfrAddr == 8'hd0);
endmodule : csp_core_status_properties
bind csp_core_status csp_core_status_properties #(.PTR_WIDTH(PTR_WIDTH))
  i_chk (.core_clk(core_clk), .arst_n(arst_n), .sfrAddr(sfrAddr),
  .sfrWe(sfrWe), .sfrWdata(sfrWdata), .sfrRe(sfrRe),
  .mainWorkReg(mainWorkReg), .aluValid(aluValid), .flagUpd(flagUpd),
  .externalMoveDone(externalMoveDone), .sfrRdata(sfrRdata),
  .statusWord(statusWord), .activePointerBit(activePointerBit),
  .moveAddr(moveAddr), .bankBase(bankBase));

//--- tb/csp_exec_model.sv
// Purpose: execution unit stand-in for the status block
// Assumes: the bench calls step once per operation
// Notes: operands turn to their inverse once the strobe drops
`timescale 1ns/1ps
module csp_exec_model (
  input wire logic core_clk,
  output logic [7:0] aluOpA,
  output logic [7:0] aluOpB,
  output logic aluSub,
  output logic aluUseCarry,
  output logic aluValid,
  output csp_pkg::csp_flag_upd_t flagUpd,
  output logic externalMoveDone
);
  import csp_pkg::*;
  // ==========================================================
  // idle levels from time zero
  initial begin
    {aluOpA, aluOpB, aluSub, aluUseCarry, aluValid} = '0;
    flagUpd = '0;
    externalMoveDone = 1'b0;
  end
  // one cycle: ctl is {sub, use carry, alu load, move done}
  task automatic step(input logic [7:0] a, input logic [7:0] b,
    input logic [3:0] ctl, input csp_flag_upd_t f);
    @(posedge core_clk);
    #1;
    {aluSub, aluUseCarry, aluValid, externalMoveDone} = ctl;
    aluOpA = a;
    aluOpB = b;
    flagUpd = f;
    @(posedge core_clk);
    #1;
    {aluValid, externalMoveDone} = 2'b00;
    flagUpd = '0;
    aluOpA = ~a;
    aluOpB = ~b;
  endtask : step
endmodule : csp_exec_model

//--- tb/tb_csp_core_status.sv
// Purpose: register and move sequences for csp_core_status
// Assumes: csp_exec_model stands in for the execution unit
// Notes: expected values follow the two register bit tables
`timescale 1ns/1ps
module tb_csp_core_status;
  import csp_pkg::*;
  logic core_clk, arst_n, sfrWe, sfrRe, aluSub, aluUseCarry, aluValid;
  logic externalMoveDone, activePointerBit;
  logic [7:0] sfrAddr, sfrWdata, mainWorkReg, aluOpA, aluOpB, sfrRdata;
  logic [7:0] statusWord, bankBase;
  logic [15:0] moveAddr;
  csp_flag_upd_t flagUpd;
  int err_count = 0;
  int check_count = 0;
  // {a, b, sub, use carry, expected carry, half, overflow}
  logic [20:0] aluTab [7] = '{
    {8'hff, 8'h01, 2'b00, 3'b110}, {8'h0e, 8'h01, 2'b01, 3'b010},
    {8'h7f, 8'h01, 2'b00, 3'b011}, {8'h00, 8'h01, 2'b10, 3'b110},
    {8'h10, 8'h0f, 2'b11, 3'b010}, {8'h80, 8'h01, 2'b10, 3'b011},
    {8'h12, 8'h34, 2'b00, 3'b000}};
  // ==========================================================
  // design and execution unit model
  csp_core_status #(.PTR_WIDTH(16)) i_dut (.core_clk(core_clk),
    .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
    .sfrWdata(sfrWdata), .sfrRe(sfrRe), .mainWorkReg(mainWorkReg),
    .aluOpA(aluOpA), .aluOpB(aluOpB), .aluSub(aluSub),
    .aluUseCarry(aluUseCarry), .aluValid(aluValid), .flagUpd(flagUpd),
    .externalMoveDone(externalMoveDone), .sfrRdata(sfrRdata),
    .statusWord(statusWord), .activePointerBit(activePointerBit),
    .moveAddr(moveAddr), .bankBase(bankBase));
  csp_exec_model i_exu (.core_clk(core_clk), .aluOpA(aluOpA),
    .aluOpB(aluOpB), .aluSub(aluSub), .aluUseCarry(aluUseCarry),
    .aluValid(aluValid), .flagUpd(flagUpd),
    .externalMoveDone(externalMoveDone));
  // ==========================================================
  // compare, register access and closing tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    {sfrWe, sfrAddr, sfrWdata} = {1'b1, a, d};
    @(posedge core_clk);
    #1;
    sfrWe = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1;
    {sfrRe, sfrAddr} = {1'b1, a};
    @(posedge core_clk);
    #1;
    sfrRe = 1'b0;
    chk({8'h00, sfrRdata}, {8'h00, exp});
  endtask : rd
  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge core_clk);
    err_count++;
    final_report();
  end
  // main sequence
  initial begin
    {arst_n, sfrWe, sfrRe, sfrAddr, sfrWdata, mainWorkReg} = '0;
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    rd(8'hd0, 8'h00);
    rd(8'h93, 8'h00);
    rd(8'h92, 8'h00);
    wr(8'hd0, 8'hff);
    rd(8'hd0, 8'hfe);
    mainWorkReg = 8'h07;
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b * 8) | 8'h22);
      chk({8'h00, bankBase}, 16'(b * 8));
    end
    rd(8'hd0, 8'h3b);
    wr(8'hd0, 8'h00);
    for (int i = 0; i < 7; i++) begin
      i_exu.step(aluTab[i][20:13], aluTab[i][12:5],
        {aluTab[i][4:3], 2'b10}, '0);
      chk({statusWord[7:6], statusWord[2]}, aluTab[i][2:0]);
    end
    i_exu.step(8'h12, 8'h34, 4'b0010, 6'b110000);
    chk(statusWord[7:6], 2'b10);
    i_exu.step(8'h00, 8'h00, 4'b0000, 6'b101011);
    chk({statusWord[7:6], statusWord[2]}, 3'b001);
    wr(8'h82, 8'hfe);
    wr(8'h93, 8'h05);
    chk(moveAddr, 16'h00fe);
    i_exu.step(8'h00, 8'h00, 4'b0001, '0);
    chk(moveAddr, 16'h0100);
    chk(activePointerBit, 1'b0);
    wr(8'h93, 8'h0b);
    i_exu.step(8'h00, 8'h00, 4'b0001, '0);
    chk(activePointerBit, 1'b1);
    chk(moveAddr, 16'h0000);
    rd(8'h93, 8'h00);
    wr(8'h93, 8'hf8);
    rd(8'h93, 8'h08);
    i_exu.step(8'h00, 8'h00, 4'b0001, '0);
    chk(activePointerBit, 1'b1);
    chk(moveAddr, 16'h0000);
    wr(8'h92, 8'h00);
    rd(8'h93, 8'h0b);
    chk(moveAddr, 16'h00ff);
    // reset again in mid-run: all state must return to zero
    arst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    chk(statusWord, 16'h0000);
    chk(moveAddr, 16'h0000);
    chk(activePointerBit, 1'b0);
    rd(8'h93, 8'h00);
    rd(8'hd0, 8'h01);
    final_report();
  end
endmodule : tb_csp_core_status
